//--- bsl_logic_crc_muldiv.sv
// Bit-slice datapath: exclusive-OR logic, no-op, CRC step, divide and multiply.
// Assumes a classic Wishbone master issuing one microword per CMD write,
// and that the master keeps the operand setup that each macro needs.
//
// Functional notes
// - XNOR when inversions match, XOR otherwise
// - Source and invert bits pick each operand
// - Logic result goes to one of four
// - No-op zeroes result, above low, match high
// - No-op holds registers, counters and latches while the async controls are clear
// - No-op may step counters or load working
// - No-op keeps carry and range flags
// - CRC updates 16-bit sum in eight steps
// - CRC step drives low branch select
// - Signed divide takes N plus three clocks
// - Zero divisor drops match at start
// - Signed divide status outputs are undefined
// - Signed iterate drives both branch selects
// - Unsigned divide takes N plus one clocks
// - Unsigned start flags valid via arith above
// - Unsigned iterate branches on carry or force-load
// - Multiply leaves high word working, low extension
// - Multiply status outputs are undefined
// - Multiply iterate branches on extension LSB
//
// The implementer's own choices: register access over Wishbone and the address map.
`timescale 1ns/1ns

module bsl_logic_crc_muldiv (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic matchOutput,
	output logic arithAboveBit,
	output logic logicAboveBit,
	output logic carryOut,
	output logic signedRangeBit,
	output logic branchSelectHi,
	output logic branchSelectLo
);

	localparam int W = bsl_pkg::WIDTH;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------

	// Byte-lane merge of a 16-bit register; upper lanes have no storage
	function automatic logic [W-1:0] laneMerge(input logic [W-1:0] old,
		input logic [W-1:0] val, input logic [3:0] sel);
		laneMerge = old;
		if (sel[0]) begin
			laneMerge[7:0] = val[7:0];
		end
		if (sel[1]) begin
			laneMerge[15:8] = val[15:8];
		end
	endfunction : laneMerge

	// Shift-and-subtract step shared by both divides
	// Returns {take, new remainder}; take set when divisor fits
	function automatic logic [W:0] divStep(input logic [W-1:0] rem,
		input logic nextBit, input logic [W-1:0] dvs);
		logic [W+1:0] shifted;
		logic [W+1:0] diff;
		shifted = {1'b0, rem, nextBit};
		diff = shifted - {2'b00, dvs};
		if (diff[W+1]) begin
			divStep = {1'b0, shifted[W-1:0]};
		end else begin
			divStep = {1'b1, diff[W-1:0]};
		end
	endfunction : divStep

	// Two's complement of a word
	function automatic logic [W-1:0] negate(input logic [W-1:0] v);
		negate = bsl_pkg::ZERO_WORD - v;
	endfunction : negate

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic ack_ff; // Bus answer
	logic [31:0] rdData_ff; // Bus read data
	logic [W-1:0] aIn_ff; // A input port value
	logic [W-1:0] bIn_ff; // B input value
	logic [W-1:0] work_ff; // Working register
	logic [W-1:0] ext_ff; // extension_work_reg
	logic [W-1:0] sigma_ff; // Result bus latch
	logic [W-1:0] memCnt_ff; // memory_counter
	logic [W-1:0] progCnt_ff; // prog_counter
	bsl_pkg::bsl_async_t async_ff; // Asynchronous controls
	bsl_pkg::bsl_status_t stat_ff; // Status outputs
	bsl_pkg::bsl_seq_t seq_ff; // Macro in progress
	logic [2:0] crcCnt_ff; // CRC step count
	logic dvdNeg_ff; // Stored dividend sign
	logic dvsNeg_ff; // Stored divisor sign

	logic [W-1:0] nxt_work;
	logic [W-1:0] nxt_ext;
	logic [W-1:0] nxt_sigma;
	logic [W-1:0] nxt_memCnt;
	logic [W-1:0] nxt_progCnt;
	bsl_pkg::bsl_status_t nxt_stat;
	bsl_pkg::bsl_seq_t nxt_seq;
	logic [2:0] nxt_crcCnt;
	logic nxt_dvdNeg;
	logic nxt_dvsNeg;

	// Request decode
	logic busReq; // New request this cycle
	logic busWr; // Write accepted this cycle
	logic step; // One datapath clock from a CMD write
	bsl_pkg::bsl_cmd_t cmd; // Microword being run
	assign busReq = wb_cyc_i && wb_stb_i && !ack_ff;
	assign busWr = busReq && wb_we_i;
	assign step = busWr && (wb_adr_i == bsl_pkg::OFS_CMD) && (wb_sel_i[1:0] != 2'b00);
	assign cmd = bsl_pkg::bsl_cmd_t'(wb_dat_i[12:0]);

	// ------------------------------------------------------------
	// Operand selection
	// ------------------------------------------------------------
	logic [W-1:0] aSrc;
	logic [W-1:0] bSrc;
	logic [W-1:0] aOp;
	logic [W-1:0] bOp;
	logic [W-1:0] stepSize;

	// Each operand chosen by its source bits, then optionally inverted
	always_comb begin
		aSrc = cmd.aChoice ? work_ff : aIn_ff;
		case ({cmd.bChoiceHi, cmd.bChoiceLo})
			bsl_pkg::BSRC_BIN: bSrc = bIn_ff;
			bsl_pkg::BSRC_WORK: bSrc = work_ff;
			bsl_pkg::BSRC_EXT: bSrc = ext_ff;
			default: bSrc = memCnt_ff;
		endcase
		aOp = cmd.aInvert ? ~aSrc : aSrc;
		bOp = cmd.bInvert ? ~bSrc : bSrc;
		stepSize = async_ff.incByTwo ? bsl_pkg::STEP_TWO : bsl_pkg::STEP_ONE;
	end

	// ------------------------------------------------------------
	// Datapath next state
	// ------------------------------------------------------------
	logic [W:0] dstep; // Divide step result
	logic [W:0] mulSum; // Multiply partial sum
	logic [W-1:0] dvsMag; // Divisor magnitude
	logic [2*W-1:0] dvdMag; // Dividend magnitude

	always_comb begin
		nxt_work = work_ff;
		nxt_ext = ext_ff;
		nxt_sigma = sigma_ff;
		nxt_memCnt = memCnt_ff;
		nxt_progCnt = progCnt_ff;
		nxt_stat = stat_ff;
		nxt_seq = seq_ff;
		nxt_crcCnt = crcCnt_ff;
		nxt_dvdNeg = dvdNeg_ff;
		nxt_dvsNeg = dvsNeg_ff;
		dvsMag = dvsNeg_ff ? negate(aIn_ff) : aIn_ff;
		dvdMag = {work_ff, ext_ff};
		dstep = '0;
		mulSum = '0;
		if (step) begin
			nxt_seq = bsl_pkg::ST_IDLE;
			case (cmd.fn)
				// Unlisted codes: only the macro tracking returns to idle
				bsl_pkg::FN_NOP: begin
					nxt_sigma = bsl_pkg::ZERO_WORD;
					nxt_stat.arithAbove = 1'b0;
					nxt_stat.logicAbove = 1'b0;
					nxt_stat.match = 1'b1;
					nxt_stat.branchHi = 1'b0;
					nxt_stat.branchLo = 1'b0;
					// Carry and range flags left alone
					// Only the asynchronous controls move state
					if (async_ff.incMem) begin
						nxt_memCnt = memCnt_ff + stepSize;
					end
					if (async_ff.incProg) begin
						nxt_progCnt = progCnt_ff + stepSize;
					end
					if (async_ff.loadWork) begin
						nxt_work = aIn_ff;
					end
				end
				bsl_pkg::FN_XOR: begin
					// Both true or both inverted gives XNOR
					nxt_sigma = ~(aOp ^ bOp);
					nxt_stat.match = (aOp == bOp);
					nxt_stat.logicAbove = (aOp > bOp);
					nxt_stat.arithAbove = ($signed(aOp) > $signed(bOp));
					case (cmd.dest)
						bsl_pkg::DST_WORK: nxt_work = ~(aOp ^ bOp);
						bsl_pkg::DST_EXT: nxt_ext = ~(aOp ^ bOp);
						bsl_pkg::DST_MEMCNT: nxt_memCnt = ~(aOp ^ bOp);
						default: nxt_progCnt = ~(aOp ^ bOp);
					endcase
				end
				bsl_pkg::FN_CRC: begin
					// One bit per clock, polynomial folded in on feedback
					nxt_seq = bsl_pkg::ST_CRC;
					nxt_crcCnt = (seq_ff == bsl_pkg::ST_CRC) ? crcCnt_ff + 3'h1 : 3'h0;
					if (work_ff[0] ^ ext_ff[0]) begin
						nxt_work = (work_ff >> 1) ^ aIn_ff;
					end else begin
						nxt_work = work_ff >> 1;
					end
					nxt_ext = ext_ff >> 1;
					// Exit branch on the eighth step
					nxt_stat.branchLo = (nxt_crcCnt == bsl_pkg::CRC_LAST);
					nxt_stat.branchHi = 1'b0;
				end
				bsl_pkg::FN_SDIV_START: begin
					// Signs stored, dividend made positive
					nxt_seq = bsl_pkg::ST_SDIV;
					nxt_dvdNeg = work_ff[W-1];
					nxt_dvsNeg = aIn_ff[W-1];
					if (work_ff[W-1]) begin
						dvdMag = ~{work_ff, ext_ff} + 32'h0000_0001;
					end
					nxt_work = dvdMag[2*W-1:W];
					nxt_ext = dvdMag[W-1:0];
					nxt_stat.match = (aIn_ff != bsl_pkg::ZERO_WORD);
				end
				bsl_pkg::FN_SDIV_ITER: begin
					nxt_seq = bsl_pkg::ST_SDIV;
					dstep = divStep(work_ff, ext_ff[W-1], dvsMag);
					nxt_work = dstep[W-1:0];
					nxt_ext = {ext_ff[W-2:0], dstep[W]};
					nxt_stat.carry = dstep[W]; // Undefined to the user
					// Four-way branch from signs and carry
					nxt_stat.branchHi = dvdNeg_ff ^ dvsNeg_ff;
					nxt_stat.branchLo = dstep[W];
				end
				bsl_pkg::FN_SDIV_FIXREM: begin
					nxt_seq = bsl_pkg::ST_SDIV;
					if (dvdNeg_ff) begin
						nxt_work = negate(work_ff);
					end
				end
				bsl_pkg::FN_SDIV_ADJQ: begin
					nxt_seq = bsl_pkg::ST_SDIV;
					if (dvdNeg_ff ^ dvsNeg_ff) begin
						nxt_ext = negate(ext_ff);
					end
				end
				bsl_pkg::FN_UDIV_START: begin
					nxt_seq = bsl_pkg::ST_UDIV;
					// Valid only if divisor exceeds upper half and the previous microword was not a divide
					nxt_stat.arithAbove = (aIn_ff > work_ff)
						&& (seq_ff != bsl_pkg::ST_SDIV)
						&& (seq_ff != bsl_pkg::ST_UDIV);
				end
				bsl_pkg::FN_UDIV_ITER: begin
					nxt_seq = bsl_pkg::ST_UDIV;
					// Force-load covers the bit shifted out of the top
					dstep = divStep(work_ff, ext_ff[W-1], aIn_ff);
					nxt_work = dstep[W-1:0];
					nxt_ext = {ext_ff[W-2:0], dstep[W]};
					nxt_stat.carry = dstep[W];
					nxt_stat.branchHi = dstep[W];
					nxt_stat.branchLo = 1'b0;
				end
				bsl_pkg::FN_MUL_ITER: begin
					nxt_seq = bsl_pkg::ST_MUL;
					// Add then shift the pair right
					mulSum = {1'b0, work_ff} + (ext_ff[0] ? {1'b0, aIn_ff} : 17'h0_0000);
					nxt_work = mulSum[W:1];
					nxt_ext = {mulSum[0], ext_ff[W-1:1]};
					nxt_stat.carry = mulSum[W]; // Undefined to the user
					nxt_stat.branchHi = ext_ff[0];
					nxt_stat.branchLo = 1'b0;
				end
				default: begin
					nxt_seq = bsl_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------

	// Answer one cycle after the request, drop it the next cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= busReq;
		end
	end

	// Read data captured with the answer; unmapped reads give zero
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdData_ff <= bsl_pkg::READ_ZERO;
		end else if (busReq && !wb_we_i) begin
			case (wb_adr_i)
				bsl_pkg::OFS_AIN: rdData_ff <= {16'h0000, aIn_ff};
				bsl_pkg::OFS_BIN: rdData_ff <= {16'h0000, bIn_ff};
				bsl_pkg::OFS_WORK: rdData_ff <= {16'h0000, work_ff};
				bsl_pkg::OFS_EXT: rdData_ff <= {16'h0000, ext_ff};
				bsl_pkg::OFS_STATUS: rdData_ff <= {25'h000_0000, stat_ff};
				bsl_pkg::OFS_RESULT: rdData_ff <= {16'h0000, sigma_ff};
				bsl_pkg::OFS_COUNT: rdData_ff <= {progCnt_ff, memCnt_ff};
				bsl_pkg::OFS_ASYNC: rdData_ff <= {28'h000_0000, async_ff};
				default: rdData_ff <= bsl_pkg::READ_ZERO;
			endcase
		end
	end

	// Operand latches and asynchronous controls, written by software
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			aIn_ff <= bsl_pkg::ZERO_WORD;
			bIn_ff <= bsl_pkg::ZERO_WORD;
			async_ff <= '0;
		end else if (busWr) begin
			if (wb_adr_i == bsl_pkg::OFS_AIN) begin
				aIn_ff <= laneMerge(aIn_ff, wb_dat_i[15:0], wb_sel_i);
			end
			if (wb_adr_i == bsl_pkg::OFS_BIN) begin
				bIn_ff <= laneMerge(bIn_ff, wb_dat_i[15:0], wb_sel_i);
			end
			if (wb_adr_i == bsl_pkg::OFS_ASYNC && wb_sel_i[0]) begin
				async_ff <= bsl_pkg::bsl_async_t'(wb_dat_i[3:0]);
			end
		end
	end

	// ------------------------------------------------------------
	// Datapath registers
	// ------------------------------------------------------------

	// Working pair: software preload or one datapath clock
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			work_ff <= bsl_pkg::ZERO_WORD;
			ext_ff <= bsl_pkg::ZERO_WORD;
		end else if (busWr && wb_adr_i == bsl_pkg::OFS_WORK) begin
			work_ff <= laneMerge(work_ff, wb_dat_i[15:0], wb_sel_i);
		end else if (busWr && wb_adr_i == bsl_pkg::OFS_EXT) begin
			ext_ff <= laneMerge(ext_ff, wb_dat_i[15:0], wb_sel_i);
		end else begin
			work_ff <= nxt_work;
			ext_ff <= nxt_ext;
		end
	end

	// Counters and result bus
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			memCnt_ff <= bsl_pkg::ZERO_WORD;
			progCnt_ff <= bsl_pkg::ZERO_WORD;
			sigma_ff <= bsl_pkg::ZERO_WORD;
		end else begin
			memCnt_ff <= nxt_memCnt;
			progCnt_ff <= nxt_progCnt;
			sigma_ff <= nxt_sigma;
		end
	end

	// Status flags and branch selects
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stat_ff <= '0;
		end else begin
			stat_ff <= nxt_stat;
		end
	end

	// Macro tracking: which sequence ran last, CRC count, stored signs
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			seq_ff <= bsl_pkg::ST_IDLE;
			crcCnt_ff <= 3'h0;
			dvdNeg_ff <= 1'b0;
			dvsNeg_ff <= 1'b0;
		end else begin
			seq_ff <= nxt_seq;
			crcCnt_ff <= nxt_crcCnt;
			dvdNeg_ff <= nxt_dvdNeg;
			dvsNeg_ff <= nxt_dvsNeg;
		end
	end

	// ------------------------------------------------------------
	// Outputs, all straight from flops
	// ------------------------------------------------------------
	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdData_ff;
	assign matchOutput = stat_ff.match;
	assign arithAboveBit = stat_ff.arithAbove;
	assign logicAboveBit = stat_ff.logicAbove;
	assign carryOut = stat_ff.carry;
	assign signedRangeBit = stat_ff.signedRange;
	assign branchSelectHi = stat_ff.branchHi;
	assign branchSelectLo = stat_ff.branchLo;

endmodule : bsl_logic_crc_muldiv

//--- bsl_pkg.sv
// Shared constants and carrier types for the bit-slice logic, CRC and mul/div block.
// Assumes a 32-bit classic Wishbone master and a 16-bit slice width.
package bsl_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int WIDTH = 16; // Slice word width (N)
	localparam int CRC_STEPS = 8; // One character of eight bits
	localparam logic [2:0] CRC_LAST = 3'h7; // Count value on the final CRC step

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CMD = 8'h00; // Microword, write runs one clock
	localparam logic [7:0] OFS_AIN = 8'h04; // A input port value
	localparam logic [7:0] OFS_BIN = 8'h08; // B input value
	localparam logic [7:0] OFS_WORK = 8'h0C; // Working register
	localparam logic [7:0] OFS_EXT = 8'h10; // Extension working register
	localparam logic [7:0] OFS_STATUS = 8'h14; // Status outputs, read only
	localparam logic [7:0] OFS_RESULT = 8'h18; // Result bus, read only
	localparam logic [7:0] OFS_COUNT = 8'h1C; // Program counter high, memory counter low
	localparam logic [7:0] OFS_ASYNC = 8'h20; // Asynchronous control bits

	// ------------------------------------------------------------
	// Function codes in opcode bits zero to four
	// ------------------------------------------------------------
	localparam logic [4:0] FN_XOR = 5'h0C;
	localparam logic [4:0] FN_CRC = 5'h10;
	localparam logic [4:0] FN_SDIV_START = 5'h11;
	localparam logic [4:0] FN_SDIV_ITER = 5'h12;
	localparam logic [4:0] FN_SDIV_FIXREM = 5'h13;
	localparam logic [4:0] FN_SDIV_ADJQ = 5'h14;
	localparam logic [4:0] FN_UDIV_START = 5'h15;
	localparam logic [4:0] FN_UDIV_ITER = 5'h16;
	localparam logic [4:0] FN_MUL_ITER = 5'h17;
	localparam logic [4:0] FN_NOP = 5'h1F;

	// Destinations of a logic result
	localparam logic [1:0] DST_WORK = 2'h0;
	localparam logic [1:0] DST_EXT = 2'h1;
	localparam logic [1:0] DST_MEMCNT = 2'h2;
	localparam logic [1:0] DST_PROGCNT = 2'h3;

	// B operand sources
	localparam logic [1:0] BSRC_BIN = 2'h0;
	localparam logic [1:0] BSRC_WORK = 2'h1;
	localparam logic [1:0] BSRC_EXT = 2'h2;
	localparam logic [1:0] BSRC_MEMCNT = 2'h3;

	localparam logic [WIDTH-1:0] ZERO_WORD = 16'h0000;
	localparam logic [WIDTH-1:0] ONES_WORD = 16'hFFFF;
	localparam logic [WIDTH-1:0] STEP_ONE = 16'h0001;
	localparam logic [WIDTH-1:0] STEP_TWO = 16'h0002;
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0] dest; // Result destination
		logic cin; // Carry in
		logic bChoiceHi; // b_operand_choice_hi
		logic bChoiceLo; // b_operand_choice_lo
		logic bInvert; // b_operand_invert
		logic aChoice; // a_operand_choice: 0 A input, 1 working register
		logic aInvert; // a_operand_invert
		logic [4:0] fn; // opcode_bit_four .. opcode_bit_zero
	} bsl_cmd_t;

	typedef struct packed {
		logic branchHi; // branch_select_hi
		logic branchLo; // branch_select_lo
		logic signedRange; // signed_range_bit
		logic carry; // Carry out
		logic logicAbove; // logic_above_bit
		logic arithAbove; // arith_above_bit
		logic match; // match_output
	} bsl_status_t;

	typedef struct packed {
		logic incByTwo; // Counters step by two
		logic loadWork; // Working register loads A input
		logic incProg; // Increment program counter
		logic incMem; // Increment memory counter
	} bsl_async_t;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_CRC = 5'b00010,
		ST_SDIV = 5'b00100,
		ST_UDIV = 5'b01000,
		ST_MUL = 5'b10000
	} bsl_seq_t;

endpackage : bsl_pkg

//--- bsl_logic_crc_muldiv_properties.sv
// Concurrent checks on the ports of the logic, CRC and mul/div slice.
// Assumes one clock domain and the register map of the shared package.
`timescale 1ns/1ns

module bsl_logic_crc_muldiv_properties (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic matchOutput,
	input wire logic arithAboveBit,
	input wire logic logicAboveBit,
	input wire logic carryOut,
	input wire logic signedRangeBit,
	input wire logic branchSelectHi,
	input wire logic branchSelectLo
);
	// ------
	// Helper logic
	// ------
	logic take; // Request taken at this edge
	logic cmdTake; // Microword write taken
	logic [15:0] aIn_ff; // Shadow of the A input register
	logic [2:0] crcRun_ff; // Consecutive CRC steps, wraps after eight

	assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign cmdTake = take && wb_we_i && wb_adr_i == bsl_pkg::OFS_CMD && wb_sel_i[0];

	// Shadow A per lane so partial writes never skew the zero test
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			aIn_ff <= 16'h0000;
		end else if (take && wb_we_i && wb_adr_i == bsl_pkg::OFS_AIN) begin
			aIn_ff[7:0] <= wb_sel_i[0] ? wb_dat_i[7:0] : aIn_ff[7:0];
			aIn_ff[15:8] <= wb_sel_i[1] ? wb_dat_i[15:8] : aIn_ff[15:8];
		end
	end

	// Any other microword restarts the CRC step count
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			crcRun_ff <= 3'h0;
		end else if (cmdTake) begin
			crcRun_ff <= (wb_dat_i[4:0] == bsl_pkg::FN_CRC) ? crcRun_ff + 3'h1 : 3'h0;
		end
	end

	// ------
	// Properties
	// ------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence nopTaken;
		cmdTake && wb_dat_i[4:0] == bsl_pkg::FN_NOP;
	endsequence
	sequence crcTaken;
		cmdTake && wb_dat_i[4:0] == bsl_pkg::FN_CRC;
	endsequence

	ack_answer_a: assert property (take |=> wb_ack_o) else $error("ack missing after request");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
	ack_cause_a: assert property (wb_ack_o |-> $past(take)) else $error("ack without request");
	unmapped_zero_a: assert property (take && !wb_we_i && wb_adr_i > 8'h23
		|=> wb_dat_o == bsl_pkg::READ_ZERO) else $error("unmapped read not zero");
	status_mirror_a: assert property (take && !wb_we_i && wb_adr_i == bsl_pkg::OFS_STATUS
		|=> wb_dat_o[6:0] == {branchSelectHi, branchSelectLo, signedRangeBit, carryOut,
		logicAboveBit, arithAboveBit, matchOutput}) else $error("status read differs from pins");
	nop_flags_a: assert property (nopTaken |=> matchOutput && !arithAboveBit && !logicAboveBit)
		else $error("no-op flags wrong");
	nop_hold_a: assert property (nopTaken |=> $stable(carryOut) && $stable(signedRangeBit))
		else $error("no-op disturbed carry or range");
	crc_branch_a: assert property (crcTaken |=> branchSelectLo == ($past(crcRun_ff) == bsl_pkg::CRC_LAST))
		else $error("CRC branch select wrong");
	sdiv_zero_a: assert property (cmdTake && wb_dat_i[4:0] == bsl_pkg::FN_SDIV_START
		|=> matchOutput == (aIn_ff != 16'h0000)) else $error("zero divisor flag wrong");
endmodule : bsl_logic_crc_muldiv_properties

bind bsl_logic_crc_muldiv bsl_logic_crc_muldiv_properties chk (.clk(clk), .rst_n(rst_n),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.matchOutput(matchOutput), .arithAboveBit(arithAboveBit), .logicAboveBit(logicAboveBit),
	.carryOut(carryOut), .signedRangeBit(signedRangeBit), .branchSelectHi(branchSelectHi),
	.branchSelectLo(branchSelectLo));

//--- bsl_ctrl_model.sv
// Microprogram controller model: issues microwords as a classic bus master.
// Assumes the slice acks every request; a lost ack raises late.
`timescale 1ns/1ns

module bsl_ctrl_model (
	input wire logic clk,
	input wire logic ack,
	input wire logic [31:0] datIn,
	output logic cyc,
	output logic stb,
	output logic we,
	output logic [7:0] adr,
	output logic [3:0] sel,
	output logic [31:0] datOut,
	output logic late
);
	// Idle bus at time zero
	initial begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'hF;
		datOut = 32'h0000_0000;
		late = 1'b0;
	end

	// ------
	// One transfer, held until ack is sampled
	// ------
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		datOut <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 40);
		r = datIn;
		late <= late | (n >= 40);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		datOut <= ~datOut; // Released data flips so stale values never match
		@(posedge clk);
	endtask : xfer

	// Operands in place before a macro starts
	task automatic prep(input logic [15:0] wk, input logic [15:0] ex, input logic [15:0] a);
		logic [31:0] r;
		xfer(1'b1, bsl_pkg::OFS_WORK, {16'h0000, wk}, r);
		xfer(1'b1, bsl_pkg::OFS_EXT, {16'h0000, ex}, r);
		xfer(1'b1, bsl_pkg::OFS_AIN, {16'h0000, a}, r);
	endtask : prep

	// Back-to-back iterate microwords
	task automatic steps(input logic [4:0] f, input int n);
		logic [31:0] r;
		for (int i = 0; i < n; i++) begin
			xfer(1'b1, bsl_pkg::OFS_CMD, {27'h0000000, f}, r);
		end
	endtask : steps
endmodule : bsl_ctrl_model

//--- tb_bsl_logic_crc_muldiv.sv
// Self-checking bench for the logic, CRC and mul/div slice.
// Assumes the controller model owns the register bus.
`timescale 1ns/1ns

module tb_bsl_logic_crc_muldiv;
	logic clk; // 10 MHz clock
	logic rst_n; // Synchronous reset
	logic cyc, stb, we, ack, late; // Bus handshake
	logic [7:0] adr; // Byte address
	logic [3:0] sel; // Byte lanes
	logic [31:0] dw, dr, q, p; // Bus data and scratch
	logic matchOut, arithAbove, logicAbove, carry, sRange, brHi, brLo; // Status pins
	logic [15:0] w, e; // Expected CRC state
	logic [15:0] xr [4] = '{16'h3366, 16'hCC99, 16'hCC99, 16'h3366}; // Logic results
	int n_errors = 0;
	int check_count = 0;
	int k;

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	bsl_ctrl_model ctl (.clk(clk), .ack(ack), .datIn(dr), .cyc(cyc), .stb(stb), .we(we),
		.adr(adr), .sel(sel), .datOut(dw), .late(late));

	bsl_logic_crc_muldiv dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr),
		.wb_ack_o(ack), .matchOutput(matchOut), .arithAboveBit(arithAbove),
		.logicAboveBit(logicAbove), .carryOut(carry), .signedRangeBit(sRange),
		.branchSelectHi(brHi), .branchSelectLo(brLo));

	// ------
	// Report and compare tasks
	// ------
	task automatic end_sim();
		$display("mismatches %0d comparisons %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_sim

	task automatic chkW(input string nm, input logic [31:0] ex, input logic [31:0] got);
		check_count++;
		if (got !== ex) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, ex, got);
		end
	endtask : chkW

	task automatic chkB(input string nm, input logic ex, input logic got);
		check_count++;
		if (got !== ex) begin
			n_errors++;
			$display("ERROR %s expected %b seen %b", nm, ex, got);
		end
	endtask : chkB

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ctl.xfer(1'b1, a, d, q);
	endtask : wr

	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] ex);
		logic [31:0] r;
		ctl.xfer(1'b0, a, 32'h0000_0000, r);
		chkW(nm, ex, r);
	endtask : rdc

	// Microword: x is dest, cin, B source, B invert, A source, A invert
	task automatic cmd(input logic [4:0] f, input logic [7:0] x);
		wr(bsl_pkg::OFS_CMD, {19'h00000, x, f});
	endtask : cmd

	// A lost ack ends the run
	always @(posedge clk) begin
		if (late === 1'b1) begin
			n_errors++;
			end_sim();
		end
	end

	// ------
	// Main sequence
	// ------
	initial begin
		rst_n = 1'b0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (k = 0; k < 10; k++) begin
			rdc("resetValue", 8'(k * 4), bsl_pkg::READ_ZERO);
		end
		// Each inversion pair, each destination
		wr(bsl_pkg::OFS_AIN, 32'h0000_F0C3);
		wr(bsl_pkg::OFS_BIN, 32'h0000_3C5A);
		for (k = 0; k < 4; k++) begin
			cmd(bsl_pkg::FN_XOR, {k[1:0], 3'h0, k[1], 1'b0, k[0]});
			rdc("logicResult", bsl_pkg::OFS_RESULT, {16'h0000, xr[k]});
		end
		rdc("destCounters", bsl_pkg::OFS_COUNT, 32'h3366_CC99);
		rdc("destExt", bsl_pkg::OFS_EXT, 32'h0000_CC99);
		cmd(bsl_pkg::FN_XOR, 8'h16);
		rdc("srcSelect", bsl_pkg::OFS_WORK, 32'h0000_FFFF);
		// No-op, junk in ignored bits
		wr(bsl_pkg::OFS_ASYNC, 32'h0000_0009);
		cmd(bsl_pkg::FN_NOP, 8'hFF);
		rdc("nopResult", bsl_pkg::OFS_RESULT, bsl_pkg::READ_ZERO);
		chkB("nopMatch", 1'b1, matchOut);
		chkB("nopAbove", 1'b0, arithAbove | logicAbove);
		rdc("nopStepTwo", bsl_pkg::OFS_COUNT, 32'h3366_CC9B);
		rdc("nopWork", bsl_pkg::OFS_WORK, 32'h0000_FFFF);
		wr(bsl_pkg::OFS_ASYNC, 32'h0000_0006);
		cmd(bsl_pkg::FN_NOP, 8'h00);
		rdc("nopLoad", bsl_pkg::OFS_WORK, 32'h0000_F0C3);
		rdc("nopStepOne", bsl_pkg::OFS_COUNT, 32'h3367_CC9B);
		wr(bsl_pkg::OFS_ASYNC, 32'h0000_0000);
		cmd(bsl_pkg::FN_NOP, 8'h00);
		rdc("nopHoldCount", bsl_pkg::OFS_COUNT, 32'h3367_CC9B);
		rdc("nopHoldExt", bsl_pkg::OFS_EXT, 32'h0000_CC99);
		// One character into the running sum
		ctl.prep(16'hFFFF, 16'h005A, 16'hA001);
		w = 16'hFFFF;
		e = 16'h005A;
		for (k = 0; k < 8; k++) begin
			cmd(bsl_pkg::FN_CRC, 8'h00);
			chkB("crcBranch", k == 7, brLo);
			w = (w >> 1) ^ ((w[0] ^ e[0]) ? 16'hA001 : 16'h0000);
			e = e >> 1;
		end
		rdc("crcSum", bsl_pkg::OFS_WORK, {16'h0000, w});
		// Unsigned multiply, branch follows multiplier bits
		ctl.prep(16'h0000, 16'hBEEF, 16'hC0DE);
		p = 32'h0000_BEEF;
		for (k = 0; k < 16; k++) begin
			cmd(bsl_pkg::FN_MUL_ITER, 8'h00);
			chkB("mulBranch", p[k], brHi);
		end
		p = 32'h0000_BEEF * 32'h0000_C0DE;
		rdc("mulHigh", bsl_pkg::OFS_WORK, {16'h0000, p[31:16]});
		rdc("mulLow", bsl_pkg::OFS_EXT, {16'h0000, p[15:0]});
		// Unsigned divide: abort, good run, start after a divide
		ctl.prep(16'h1234, 16'h5678, 16'h1000);
		cmd(bsl_pkg::FN_UDIV_START, 8'h00);
		chkB("udivAbort", 1'b0, arithAbove);
		cmd(bsl_pkg::FN_NOP, 8'h00);
		ctl.prep(16'h1234, 16'h5678, 16'h9ABC);
		cmd(bsl_pkg::FN_UDIV_START, 8'h00);
		chkB("udivStart", 1'b1, arithAbove);
		ctl.steps(bsl_pkg::FN_UDIV_ITER, 15);
		chkB("udivFit", 1'b1, brHi);
		cmd(bsl_pkg::FN_UDIV_ITER, 8'h00);
		rdc("udivQuot", bsl_pkg::OFS_EXT, 32'h1234_5678 / 32'h0000_9ABC);
		rdc("udivRem", bsl_pkg::OFS_WORK, 32'h1234_5678 % 32'h0000_9ABC);
		ctl.prep(16'h1234, 16'h5678, 16'h9ABC);
		cmd(bsl_pkg::FN_UDIV_START, 8'h00);
		chkB("udivAfterDiv", 1'b0, arithAbove);
		// Signed divide: zero divisor, then -1000 by 7
		ctl.prep(16'hFFFF, 16'hFC18, 16'h0000);
		cmd(bsl_pkg::FN_SDIV_START, 8'h00);
		chkB("sdivZero", 1'b0, matchOut);
		ctl.prep(16'hFFFF, 16'hFC18, 16'h0007);
		cmd(bsl_pkg::FN_SDIV_START, 8'h00);
		chkB("sdivNonzero", 1'b1, matchOut);
		ctl.steps(bsl_pkg::FN_SDIV_ITER, 16);
		cmd(bsl_pkg::FN_SDIV_FIXREM, 8'h00);
		cmd(bsl_pkg::FN_SDIV_ADJQ, 8'h00);
		chkB("sdivSign", 1'b1, brHi);
		rdc("sdivQuot", bsl_pkg::OFS_EXT, 32'h0000_FF72);
		rdc("sdivRem", bsl_pkg::OFS_WORK, 32'h0000_FFFA);
		end_sim();
	end
endmodule : tb_bsl_logic_crc_muldiv
